/* File: src/host_bus_autodetect_port.sv */
// Host parallel bus port with style detection and pointer RAM access
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
// What this block does
// - Detect strobe style from first write
// - Default to separate read and write strobes
// - Keep strobe style until hardware reset
// - Address bit zero activity means non-multiplexed
// - Default multiplexed; keep bus type until reset
// - One odd write plus read settles both
// - Chip select with read strobe freezes modes
// - Direct register decode, byte bus, no waits
// - Pointer auto-increment or random RAM access
// - RAM read bytes prefetched into data register
// - Without auto-increment, only pointer low write reloads data
// - Host data write held, then stored
// - Pointer load for reads starts prefetch
// - Reading diagnostic status clears it
// - Fast mode captures address on delayed strobe
// - Second delay: late rise, prompt fall
// - Read data uses unsampled address, raw strobe
// - Side effects come from delayed pulse
// - Strobe delays fifteen plus ten ns, rounded up to one cycle each
// - Fast read select resets to normal
// - Same scheme for direction plus data strobe
module host_bus_autodetect_port (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Host bus pins
   input wire logic chip_select_n_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic addr_latch_i,
   input wire logic [host_port_pkg::HADDR_W-1:0] register_address_bits_i,
   input wire logic [host_port_pkg::DATA_W-1:0] host_data_i,
   output logic [host_port_pkg::DATA_W-1:0] host_data_o,
   output logic host_data_oe_o,
   // AXI4-Lite write channels
   input wire logic [host_port_pkg::AXI_AW-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [host_port_pkg::AXI_DW-1:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic bvalid_o,
   output logic [1:0] bresp_o,
   input wire logic bready_i,
   // AXI4-Lite read channels
   input wire logic [host_port_pkg::AXI_AW-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic rvalid_o,
   output logic [host_port_pkg::AXI_DW-1:0] rdata_o,
   output logic [1:0] rresp_o,
   input wire logic rready_i
);
   function automatic logic at(input logic [2:0] a, input logic [2:0] r,
                               input logic en);
      return en && (a == r);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == host_port_pkg::OFS_CTRL || a == host_port_pkg::OFS_STATUS
         || a == host_port_pkg::OFS_DIAGNOSTIC_STATUS_REG || a == host_port_pkg::OFS_NEXT_ID;
   endfunction

   //**********************************************************
   // Pin synchroniser
   //**********************************************************
   host_port_pkg::pins_t pin_meta;
   host_port_pkg::pins_t pin_sync;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pin_meta <= host_port_pkg::PIN_IDLE;
         pin_sync <= host_port_pkg::PIN_IDLE;
      end else begin
         pin_meta <= {chip_select_n_i, read_strobe_n_i, write_strobe_n_i,
                      addr_latch_i, register_address_bits_i, host_data_i};
         pin_sync <= pin_meta;
      end
   end

   //**********************************************************
   // Bus style detection
   //**********************************************************
   host_port_pkg::mode_t mode;

   wire strobe_any = !pin_sync.wr_n || !pin_sync.rd_n;
   wire sep_evt = !pin_sync.wr_n && pin_sync.rd_n;
   wire ds_evt = !pin_sync.wr_n && !pin_sync.rd_n;
   wire a0_evt = strobe_any && pin_sync.addr[0];
   wire freeze_evt = !pin_sync.cs_n && !pin_sync.rd_n;
   wire style_open = !mode.frozen && !mode.style_known;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode <= '0;
      end else begin
         // A direction-style write holds both pins low together
         if (style_open && (sep_evt || ds_evt)) begin
            mode.style_known <= 1'b1;
            mode.ds_style <= ds_evt;
         end
         if (!mode.frozen && a0_evt) begin
            mode.nonmux <= 1'b1;
         end
         if (freeze_evt) begin
            mode.frozen <= 1'b1;
         end
      end
   end

   //**********************************************************
   // Access decode
   //**********************************************************
   // In direction style the read pin carries direction, write pin strobe
   wire ds_low = !pin_sync.wr_n;
   wire rd_act = mode.ds_style ? (ds_low && pin_sync.rd_n)
                               : !pin_sync.rd_n;
   wire wr_act = mode.ds_style ? (ds_low && !pin_sync.rd_n)
                               : (ds_low && pin_sync.rd_n);
   wire cs_act = !pin_sync.cs_n;
   logic [2:0] mux_addr;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mux_addr <= '0;
      end else if (pin_sync.ale) begin
         mux_addr <= pin_sync.data[2:0];
      end
   end

   wire [2:0] haddr = mode.nonmux ? pin_sync.addr : mux_addr;
   host_port_pkg::sel_t sel_now;
   host_port_pkg::sel_t fx_sel;
   logic fx;
   logic fast;
   assign sel_now = {cs_act, haddr};

   read_strobe_shaper shaper (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .fast_i(fast),
      .act_i(rd_act),
      .sel_i(sel_now),
      .fx_o(fx),
      .fx_sel_o(fx_sel)
   );

   wire rd_fx = fx && fx_sel.cs;
   wire diagnostic_status_reg_clr = at(fx_sel.addr, host_port_pkg::HREG_DIAGNOSTIC_STATUS_REG, rd_fx);
   wire data_rd = at(fx_sel.addr, host_port_pkg::HREG_DATA, rd_fx);
   wire nid_rd = at(fx_sel.addr, host_port_pkg::HREG_NEXT_ID, rd_fx);

   //**********************************************************
   // Host writes
   //**********************************************************
   wire wr_hit = cs_act && wr_act;
   logic wr_prev;
   logic [2:0] wr_addr_q;
   logic [7:0] wr_data_q;

   // Act at the end of the strobe, when the data has settled
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_prev <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
      end else begin
         wr_prev <= wr_hit;
         if (wr_hit) begin
            wr_addr_q <= haddr;
            wr_data_q <= pin_sync.data;
         end
      end
   end

   wire wr_done = wr_prev && !wr_hit;
   wire ld_hi = at(wr_addr_q, host_port_pkg::HREG_PTR_HI, wr_done);
   wire ld_lo = at(wr_addr_q, host_port_pkg::HREG_PTR_LO, wr_done);
   wire ld_data = at(wr_addr_q, host_port_pkg::HREG_DATA, wr_done);

   //**********************************************************
   // Pointer and packet RAM
   //**********************************************************
   logic [host_port_pkg::PTR_W-1:0] ptr;
   logic ptr_rd;
   logic ptr_inc;
   logic [7:0] data_reg;
   logic fetch_pend;
   logic store_pend;
   logic adv_pend;
   logic [7:0] ram_q;
   host_port_pkg::ram_state_t ram_state;
   host_port_pkg::ram_state_t next_ram_state;

   wire idle = ram_state == host_port_pkg::RAM_IDLE;
   wire ram_we = idle && store_pend;
   wire ram_re = idle && !store_pend && fetch_pend;
   // Advance only after the strobe ends, so the byte being read holds
   wire adv_go = adv_pend && !rd_act;
   wire step = (ram_state == host_port_pkg::RAM_STORE && ptr_inc)
      || adv_go;
   wire [host_port_pkg::PTR_W-1:0] ptr_next1 =
      host_port_pkg::PTR_W'(ptr + 1'b1);
   wire [host_port_pkg::PTR_W-1:0] next_ptr =
      ld_hi ? {wr_data_q[2:0], ptr[7:0]} :
      ld_lo ? {ptr[10:8], wr_data_q} :
      step ? ptr_next1 : ptr;
   wire next_fetch = (ld_lo && ptr_rd) || adv_go
      || (fetch_pend && !ram_re);
   wire next_store = ld_data || (store_pend && !ram_we);
   wire next_adv = (data_rd && ptr_inc) || (adv_pend && !adv_go);
   wire [7:0] next_data = ld_data ? wr_data_q :
      (ram_state == host_port_pkg::RAM_FETCH) ? ram_q : data_reg;

   always_comb begin
      case (ram_state)
         host_port_pkg::RAM_IDLE: begin
            if (ram_we) begin
               next_ram_state = host_port_pkg::RAM_STORE;
            end else if (ram_re) begin
               next_ram_state = host_port_pkg::RAM_FETCH;
            end else begin
               next_ram_state = host_port_pkg::RAM_IDLE;
            end
         end
         default: next_ram_state = host_port_pkg::RAM_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ptr <= '0;
         ptr_rd <= 1'b0;
         ptr_inc <= 1'b0;
         ram_state <= host_port_pkg::RAM_IDLE;
      end else begin
         ptr <= next_ptr;
         ram_state <= next_ram_state;
         if (ld_hi) begin
            ptr_rd <= wr_data_q[host_port_pkg::PTR_HI_RD_BIT];
            ptr_inc <= wr_data_q[host_port_pkg::PTR_HI_INC_BIT];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         data_reg <= '0;
         fetch_pend <= 1'b0;
         store_pend <= 1'b0;
         adv_pend <= 1'b0;
      end else begin
         data_reg <= next_data;
         fetch_pend <= next_fetch;
         store_pend <= next_store;
         adv_pend <= next_adv;
      end
   end

   packet_ram ram (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .addr_i(ptr),
      .we_i(ram_we),
      .re_i(ram_re),
      .wd_i(data_reg),
      .q_o(ram_q)
   );

   //**********************************************************
   // Diagnostic status and host read path
   //**********************************************************
   logic [7:0] diagnostic_status_reg;
   logic [7:0] next_id;
   logic nid_seen;
   logic status_rd;
   logic [7:0] diagnostic_status_reg_set;
   logic clr_pend;
   // Clear once the strobe ends, so the read itself returns the value
   wire clr_go = clr_pend && !rd_act;
   wire next_clr_pend = diagnostic_status_reg_clr || (clr_pend && rd_act);
   // A network event in the clearing cycle survives the clear
   wire [7:0] next_diagnostic_status_reg = (diagnostic_status_reg & ~{8{clr_go}}) | diagnostic_status_reg_set;
   wire next_nid_seen = nid_rd || (nid_seen && !status_rd);
   wire [7:0] hreg_q =
      (haddr == host_port_pkg::HREG_DIAGNOSTIC_STATUS_REG) ? diagnostic_status_reg :
      (haddr == host_port_pkg::HREG_PTR_HI) ?
         {ptr_rd, ptr_inc, 3'h0, ptr[10:8]} :
      (haddr == host_port_pkg::HREG_PTR_LO) ? ptr[7:0] :
      (haddr == host_port_pkg::HREG_DATA) ? data_reg :
      (haddr == host_port_pkg::HREG_NEXT_ID) ? next_id : 8'h00;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         diagnostic_status_reg <= '0;
         clr_pend <= 1'b0;
         nid_seen <= 1'b0;
         host_data_o <= '0;
         host_data_oe_o <= 1'b0;
      end else begin
         diagnostic_status_reg <= next_diagnostic_status_reg;
         clr_pend <= next_clr_pend;
         nid_seen <= next_nid_seen;
         host_data_o <= hreg_q;
         host_data_oe_o <= cs_act && rd_act;
      end
   end

   //**********************************************************
   // AXI4-Lite register slave
   //**********************************************************
   logic aw_free;
   logic w_free;
   logic ar_free;
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] s_q;
   wire wr_commit = !aw_free && !w_free && !bvalid_o;
   wire wr_lane0 = wr_commit && s_q[0];
   wire ar_take = ar_free && arvalid_i;
   wire [31:0] axi_q =
      (araddr_i == host_port_pkg::OFS_CTRL) ? {31'h0, fast} :
      (araddr_i == host_port_pkg::OFS_STATUS) ? {27'h0, nid_seen, mode} :
      (araddr_i == host_port_pkg::OFS_DIAGNOSTIC_STATUS_REG) ? {24'h0, diagnostic_status_reg} :
      (araddr_i == host_port_pkg::OFS_NEXT_ID) ? {24'h0, next_id} : 32'h0;
   assign awready_o = aw_free;
   assign wready_o = w_free;
   assign arready_o = ar_free;
   assign status_rd = ar_take && araddr_i == host_port_pkg::OFS_STATUS;
   assign diagnostic_status_reg_set = (wr_lane0 && aw_q == host_port_pkg::OFS_DIAGNOSTIC_STATUS_REG)
      ? w_q[7:0] : 8'h00;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         aw_free <= 1'b1;
         w_free <= 1'b1;
         aw_q <= '0;
         w_q <= '0;
         s_q <= '0;
         bvalid_o <= 1'b0;
         bresp_o <= host_port_pkg::RESP_OKAY;
      end else begin
         if (aw_free && awvalid_i) begin
            aw_free <= 1'b0;
            aw_q <= awaddr_i;
         end
         if (w_free && wvalid_i) begin
            w_free <= 1'b0;
            w_q <= wdata_i;
            s_q <= wstrb_i;
         end
         if (wr_commit) begin
            bvalid_o <= 1'b1;
            bresp_o <= mapped(aw_q) ? host_port_pkg::RESP_OKAY
                                    : host_port_pkg::RESP_SLVERR;
         end
         if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
            aw_free <= 1'b1;
            w_free <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fast <= 1'b0;
         next_id <= '0;
      end else if (wr_lane0) begin
         if (aw_q == host_port_pkg::OFS_CTRL) begin
            fast <= w_q[host_port_pkg::CTRL_FAST_BIT];
         end
         if (aw_q == host_port_pkg::OFS_NEXT_ID) begin
            next_id <= w_q[7:0];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ar_free <= 1'b1;
         rvalid_o <= 1'b0;
         rdata_o <= '0;
         rresp_o <= host_port_pkg::RESP_OKAY;
      end else begin
         if (ar_take) begin
            ar_free <= 1'b0;
            rvalid_o <= 1'b1;
            rdata_o <= axi_q;
            rresp_o <= mapped(araddr_i) ? host_port_pkg::RESP_OKAY
                                        : host_port_pkg::RESP_SLVERR;
         end
         if (rvalid_o && rready_i) begin
            rvalid_o <= 1'b0;
            ar_free <= 1'b1;
         end
      end
   end

   //**********************************************************
   // Checks
   //**********************************************************
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_fetch;
      ram_state == host_port_pkg::RAM_FETCH ##1 idle;
   endsequence
   sequence s_store;
      ram_we ##1 ram_state == host_port_pkg::RAM_STORE;
   endsequence

   AST_STYLE_DEFAULT: assert property (!mode.style_known |-> !mode.ds_style)
      else $error("strobe style left default early");
   AST_STYLE_HOLD: assert property (mode.style_known |=>
      mode.style_known && $stable(mode.ds_style))
      else $error("strobe style changed after detection");
   AST_NONMUX_SEEN: assert property ((!mode.frozen && a0_evt) |=>
      mode.nonmux) else $error("address bit zero activity missed");
   AST_BUS_HOLD: assert property ($rose(mode.nonmux) |->
      $past(a0_evt) && !$past(mode.frozen))
      else $error("bus type changed without cause");
   AST_FREEZE: assert property (mode.frozen |=> $stable(mode))
      else $error("modes moved after freeze");
   AST_PREFETCH: assert property ((ld_lo && ptr_rd && idle &&
      !store_pend && !fetch_pend) |-> ##2 s_fetch)
      else $error("pointer load did not prefetch");
   AST_NO_RELOAD: assert property ((data_rd && !ptr_inc && idle &&
      !fetch_pend && !store_pend && !ld_data) |=> $stable(data_reg))
      else $error("data read reloaded the data register");
   AST_WRITE_STORE: assert property ((ld_data && idle &&
      !store_pend) |=> data_reg == $past(wr_data_q) ##0 s_store)
      else $error("data write not held then stored");
   AST_DIAGNOSTIC_STATUS_REG_CLEAR: assert property ((clr_go && diagnostic_status_reg_set == 8'h00) |=>
      diagnostic_status_reg == 8'h00) else $error("diagnostic read did not clear");
   AST_READ_DRIVE: assert property ((cs_act && rd_act) |=>
      host_data_oe_o && host_data_o == $past(hreg_q))
      else $error("read data path not driven");
endmodule

/* File: src/host_port_pkg.sv */
// Constants and types shared by the host bus port files
package host_port_pkg;
   localparam int DATA_W = 8;
   localparam int HADDR_W = 3;
   localparam int PTR_W = 11;
   localparam int RAM_DEPTH = 2 ** PTR_W;
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;

   // Host-side register addresses
   localparam logic [2:0] HREG_DIAGNOSTIC_STATUS_REG = 3'h0;
   localparam logic [2:0] HREG_PTR_HI = 3'h1;
   localparam logic [2:0] HREG_PTR_LO = 3'h2;
   localparam logic [2:0] HREG_DATA = 3'h3;
   localparam logic [2:0] HREG_NEXT_ID = 3'h4;
   localparam int PTR_HI_RD_BIT = 7;
   localparam int PTR_HI_INC_BIT = 6;

   // AXI4-Lite register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DIAGNOSTIC_STATUS_REG = 8'h08;
   localparam logic [7:0] OFS_NEXT_ID = 8'h0c;
   localparam int CTRL_FAST_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int RD_DLY1_NS = 15;
   localparam int RD_DLY2_NS = 10;
   function automatic int cycles_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int RD_DLY1_CYC = cycles_up(RD_DLY1_NS);
   localparam int RD_DLY2_CYC = cycles_up(RD_DLY2_NS);

   typedef enum logic [1:0] {
      RAM_IDLE = 2'h0,
      RAM_FETCH = 2'h1,
      RAM_STORE = 2'h3
   } ram_state_t;

   typedef struct packed {
      logic frozen;
      logic nonmux;
      logic style_known;
      logic ds_style;
   } mode_t;

   typedef struct packed {
      logic cs;
      logic [HADDR_W-1:0] addr;
   } sel_t;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic ale;
      logic [HADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pins_t;

   localparam pins_t PIN_IDLE = 15'h7000;
endpackage

/* File: src/packet_ram.sv */
// Packet buffer storage with one synchronous port
`timescale 1ns/1ns
module packet_ram (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Access port
   input wire logic [host_port_pkg::PTR_W-1:0] addr_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [host_port_pkg::DATA_W-1:0] wd_i,
   output logic [host_port_pkg::DATA_W-1:0] q_o
);
   logic [host_port_pkg::DATA_W-1:0] mem [host_port_pkg::RAM_DEPTH];

   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wd_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         q_o <= '0;
      end else if (re_i) begin
         q_o <= mem[addr_i];
      end
   end
endmodule

/* File: src/read_strobe_shaper.sv */
// Read strobe delay, address capture and read side-effect pulse
`timescale 1ns/1ns
module read_strobe_shaper (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Control
   input wire logic fast_i,
   // Read strobe and selection, already synchronised
   input wire logic act_i,
   input wire host_port_pkg::sel_t sel_i,
   // Side-effect pulse and the selection it belongs to
   output logic fx_o,
   output host_port_pkg::sel_t fx_sel_o
);
   localparam int DLY1 = host_port_pkg::RD_DLY1_CYC;
   localparam int DLY2 = host_port_pkg::RD_DLY2_CYC;
   localparam int FX_AT = DLY1 + DLY2 + 1;
   // Cycles from the end of the three-cycle antecedent to the pulse
   localparam int FX_LAG = FX_AT - 2;

   logic [DLY1-1:0] sr1;
   logic [DLY2-1:0] sr2;
   logic act_q;
   logic d1_q;
   logic d2_q;
   host_port_pkg::sel_t cap;

   wire d1 = sr1[DLY1-1];
   // Trailing edge follows the strobe, so cap stays valid under d2
   wire d2 = sr2[DLY2-1] && act_i;
   wire d1_rise = d1 && !d1_q;
   wire d2_rise = d2 && !d2_q;
   wire act_rise = act_i && !act_q;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sr1 <= '0;
         sr2 <= '0;
         act_q <= 1'b0;
         d1_q <= 1'b0;
         d2_q <= 1'b0;
      end else begin
         sr1 <= DLY1'({sr1, act_i});
         sr2 <= DLY2'({sr2, d1});
         act_q <= act_i;
         d1_q <= d1;
         d2_q <= d2;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cap <= '0;
      end else if (d1_rise) begin
         cap <= sel_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fx_o <= 1'b0;
         fx_sel_o <= '0;
      end else begin
         fx_o <= fast_i ? d2_rise : act_rise;
         fx_sel_o <= fast_i ? cap : sel_i;
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   AST_FAST_PULSE_LATE: assert property (
      (fast_i && $rose(act_i) ##1 (fast_i && act_i)[*2])
      |-> ##[FX_LAG:FX_LAG] fx_o && fx_sel_o == cap)
      else $error("fast read pulse not at delayed strobe");
   AST_CAP_STABLE: assert property (
      (fast_i && d2) |=> $stable(cap) || !d2)
      else $error("captured address moved under read pulse");
   AST_NORMAL_DIRECT: assert property (
      (!fast_i && act_rise) |=> fx_o && fx_sel_o == $past(sel_i))
      else $error("normal read pulse not direct");
endmodule

/* File: verification/host_cpu_model.sv */
// Host microcontroller model driving the byte-wide port pins
`timescale 1ns/1ns
module host_cpu_model (
   // Clock
   input wire logic core_clk_i,
   // Pins toward the port
   output logic chip_select_n_o,
   output logic read_strobe_n_o,
   output logic write_strobe_n_o,
   output logic [host_port_pkg::HADDR_W-1:0] addr_o,
   output logic [host_port_pkg::DATA_W-1:0] data_o,
   input wire logic [host_port_pkg::DATA_W-1:0] data_i,
   input wire logic data_oe_i
);
   initial begin
      chip_select_n_o = 1'b1;
      read_strobe_n_o = 1'b1;
      write_strobe_n_o = 1'b1;
      addr_o = 3'h0;
      data_o = 8'h00;
   end

   // ****
   // Bus cycles
   // ****
   // Six-cycle strobes cover sync plus both read delays in fast mode
   task automatic idle();
      chip_select_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
   endtask

   // Direction-style write drives the read pin low with the strobe
   task automatic hwr(input logic [2:0] a, input logic [7:0] d,
                      input logic dir);
      addr_o <= a;
      data_o <= d;
      chip_select_n_o <= 1'b0;
      read_strobe_n_o <= dir;
      write_strobe_n_o <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      data_o <= ~d;
      idle();
   endtask

   task automatic hrd(input logic [2:0] a, output logic [7:0] q,
                      output logic oe);
      addr_o <= a;
      chip_select_n_o <= 1'b0;
      read_strobe_n_o <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      @(negedge core_clk_i);
      q = data_i;
      oe = data_oe_i;
      @(posedge core_clk_i);
      idle();
   endtask
endmodule

/* File: verification/host_bus_autodetect_port_test.sv */
// Self-checking bench for the host bus port
`timescale 1ns/1ns
module host_bus_autodetect_port_test;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, hoe, cs_n, rd_n, wr_n;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [7:0] hq, hd;
   logic [2:0] ha;
   int error_cnt = 0;
   int checked = 0;

   always #50 core_clk_i = ~core_clk_i;

   host_bus_autodetect_port host_bus_autodetect_port_inst (
      .core_clk_i(core_clk_i), .rst_i(rst_i),
      .chip_select_n_i(cs_n), .read_strobe_n_i(rd_n),
      .write_strobe_n_i(wr_n), .addr_latch_i(1'b0),
      .register_address_bits_i(ha), .host_data_i(hd),
      .host_data_o(hq), .host_data_oe_o(hoe),
      .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
      .wdata_i(wdata), .wstrb_i(4'h1), .wvalid_i(wvalid),
      .wready_o(wready), .bvalid_o(bvalid), .bresp_o(bresp),
      .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
      .arready_o(arready), .rvalid_o(rvalid), .rdata_o(rdata),
      .rresp_o(rresp), .rready_i(rready));

   host_cpu_model host_cpu_model_inst (
      .core_clk_i(core_clk_i), .chip_select_n_o(cs_n),
      .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .addr_o(ha),
      .data_o(hd), .data_i(hq), .data_oe_i(hoe));

   // ****
   // Tasks
   // ****
   task complete_run();
      if (error_cnt == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task check(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %0t seen %h exp %h", $time, s, e);
      end
   endtask

   // Ready is sampled mid-cycle, where the design's outputs are settled
   task aw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] o);
      logic ta, tw, tb;
      int i;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      for (i = 0; i < 50 && !tb; i++) begin
         @(negedge core_clk_i);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         o = bresp;
         @(posedge core_clk_i);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
      @(posedge core_clk_i);
      if (!tb) begin
         error_cnt++;
         complete_run();
      end
   endtask

   task ar(input logic [7:0] a, output logic [31:0] v, output logic [1:0] o);
      logic ta, tr;
      int i;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      for (i = 0; i < 50 && !tr; i++) begin
         @(negedge core_clk_i);
         ta = arvalid && arready;
         tr = rvalid;
         v = rdata;
         o = rresp;
         @(posedge core_clk_i);
         if (ta)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge core_clk_i);
      if (!tr) begin
         error_cnt++;
         complete_run();
      end
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] e);
      ar(a, d, r);
      check(d, e);
      check({30'h0, r}, {30'h0, host_port_pkg::RESP_OKAY});
   endtask

   task hw(input logic [2:0] a, input logic [7:0] v);
      host_cpu_model_inst.hwr(a, v, 1'b1);
   endtask

   task hchk(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] q;
      logic o;
      host_cpu_model_inst.hrd(a, q, o);
      check({23'h0, o, q}, {23'h0, 1'b1, e});
   endtask

   // ****
   // Sequence
   // ****
   initial begin
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rchk(host_port_pkg::OFS_STATUS, 32'h0);
      rchk(host_port_pkg::OFS_CTRL, 32'h0);
      hw(3'h1, 8'h00);
      rchk(host_port_pkg::OFS_STATUS, 32'h6);
      hchk(3'h1, 8'h00);
      rchk(host_port_pkg::OFS_STATUS, 32'he);
      host_cpu_model_inst.hwr(3'h0, 8'h00, 1'b0);
      rchk(host_port_pkg::OFS_STATUS, 32'he);
      hw(3'h1, 8'h40);
      hw(3'h2, 8'h10);
      hw(3'h3, 8'ha5);
      hw(3'h3, 8'h5a);
      hw(3'h1, 8'hc0);
      hw(3'h2, 8'h10);
      hchk(3'h3, 8'ha5);
      hchk(3'h3, 8'h5a);
      hw(3'h1, 8'h80);
      hw(3'h2, 8'h11);
      hchk(3'h3, 8'h5a);
      hchk(3'h3, 8'h5a);
      aw(host_port_pkg::OFS_DIAGNOSTIC_STATUS_REG, 32'h3c, r);
      check({30'h0, r}, {30'h0, host_port_pkg::RESP_OKAY});
      hchk(3'h0, 8'h3c);
      rchk(host_port_pkg::OFS_DIAGNOSTIC_STATUS_REG, 32'h0);
      aw(host_port_pkg::OFS_NEXT_ID, 32'h2b, r);
      hchk(3'h4, 8'h2b);
      rchk(host_port_pkg::OFS_STATUS, 32'h1e);
      rchk(host_port_pkg::OFS_STATUS, 32'he);
      aw(host_port_pkg::OFS_CTRL, 32'h1, r);
      rchk(host_port_pkg::OFS_CTRL, 32'h1);
      aw(host_port_pkg::OFS_DIAGNOSTIC_STATUS_REG, 32'h81, r);
      hchk(3'h0, 8'h81);
      rchk(host_port_pkg::OFS_DIAGNOSTIC_STATUS_REG, 32'h0);
      hchk(3'h4, 8'h2b);
      rchk(host_port_pkg::OFS_STATUS, 32'h1e);
      aw(8'h10, 32'h1, r);
      check({30'h0, r}, {30'h0, host_port_pkg::RESP_SLVERR});
      ar(8'h10, d, r);
      check({30'h0, r}, {30'h0, host_port_pkg::RESP_SLVERR});
      rst_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rchk(host_port_pkg::OFS_CTRL, 32'h0);
      host_cpu_model_inst.hwr(3'h0, 8'h00, 1'b0);
      rchk(host_port_pkg::OFS_STATUS, 32'hb);
      complete_run();
   end
endmodule
